// *** hdl/fbp_params.svh ***
// Constants for the flash block-protect / command-entry host controller.
// Assumes a 10 MHz ref_clk_i; all counts are in clock cycles.
`ifndef FBP_PARAMS_SVH
`define FBP_PARAMS_SVH
`define FBP_CLK_NS          100
`define FBP_UNPROT_US       10000
`define FBP_PROT_US         100
`define FBP_UNPROT_CYC      ((`FBP_UNPROT_US * 1000 + `FBP_CLK_NS - 1) / `FBP_CLK_NS)
`define FBP_PROT_CYC        ((`FBP_PROT_US * 1000 + `FBP_CLK_NS - 1) / `FBP_CLK_NS)
`define FBP_BUS_CYC         2
`define FBP_UNLOCK_ADDR1    19'h05555
`define FBP_UNLOCK_ADDR2    19'h02aaa
`define FBP_UNLOCK_DATA1    8'haa
`define FBP_UNLOCK_DATA2    8'h55
`define FBP_CMD_SIGNATURE   8'h90
`define FBP_CMD_READ_RESET  8'hf0
`define FBP_CMD_PROGRAM     8'ha0
`define FBP_CMD_ERASE_SETUP 8'h80
`define FBP_CMD_BLOCK_ERASE 8'h30
`define FBP_CMD_CHIP_ERASE  8'h10
`define FBP_A0_BIT          0
`define FBP_A1_BIT          1
`define FBP_A6_BIT          6
`define FBP_A12_BIT         12
`define FBP_A15_BIT         15
`define FBP_BLK_LSB         13
`define FBP_STAT_PROTECTED  8'h01
`define FBP_STAT_UNPROT     8'h00
`endif

// *** hdl/fbp_pkg.sv ***
// Types for the flash block-protect / command-entry host controller.
// Assumes fbp_params.svh for the numeric constants.
package fbp_pkg;
   typedef enum logic [2:0] {
      FBP_OP_READ,
      FBP_OP_WRITE_SEQ,
      FBP_OP_PROTECT,
      FBP_OP_UNPROTECT,
      FBP_OP_VERIFY_PROT,
      FBP_OP_VERIFY_UNPROT,
      FBP_OP_SIGNATURE
   } fbp_op_type;
   typedef enum logic [2:0] {
      FBP_SEQ_SINGLE,
      FBP_SEQ_READ_RESET,
      FBP_SEQ_SIGNATURE,
      FBP_SEQ_PROGRAM,
      FBP_SEQ_BLOCK_ERASE,
      FBP_SEQ_CHIP_ERASE
   } fbp_seq_type;
endpackage

// *** hdl/fbp_cyc_if.sv ***
// Bus-cycle carrier between the sequencer and the pin driver.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface fbp_cyc_if;
   logic        req;
   logic        wr;
   logic [18:0] addr;
   logic [7:0]  wdata;
   logic        done;
   logic [7:0]  rdata;
   modport seq (output req, wr, addr, wdata, input done, rdata);
   modport drv (input req, wr, addr, wdata, output done, rdata);
endinterface

// *** hdl/fbp_bus_cycle.sv ***
// Pin driver: turns one requested byte read or write into flash pin activity.
// Assumes ref_clk_i at 10 MHz and data pins resolved by the testbench.
`timescale 1ns/1ns
`include "fbp_params.svh"
module fbp_bus_cycle
   import fbp_pkg::*;
(
   input  wire logic  ref_clk_i,
   input  wire logic  reset_i,
   fbp_cyc_if.drv     cyc,
   input  wire logic  hold_i,
   input  wire logic [7:0] dq_i,
   output logic [18:0] addr_o,
   output logic [7:0]  dq_o,
   output logic        dq_oe_o,
   output logic        chip_en_n_o,
   output logic        write_en_n_o,
   output logic        out_en_n_o
);
   logic [1:0] phase;
   logic       active;
   logic       is_wr;
   wire        last_phase = (phase == 2'(`FBP_BUS_CYC));

   // Address set up first, strobe low, then strobe released with data held
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         active <= 1'b0;
         phase <= 2'h0;
         is_wr <= 1'b0;
         addr_o <= 19'h00000;
         dq_o <= 8'h00;
         cyc.rdata <= 8'h00;
      end else if (!active && cyc.req) begin
         active <= 1'b1;
         phase <= 2'h0;
         is_wr <= cyc.wr;
         addr_o <= cyc.addr;
         dq_o <= cyc.wdata;
      end else if (active && !hold_i) begin
         phase <= phase + 2'h1;
         if (last_phase) begin
            active <= 1'b0;
            if (!is_wr) cyc.rdata <= dq_i;       // Sampled while output enable is low
         end
      end
   end

   // Address goes out before the write strobe falls and data stays past its rise
   assign chip_en_n_o  = !active;
   assign write_en_n_o = !(active && is_wr && phase != 2'h0 && !last_phase);
   assign out_en_n_o   = !(active && !is_wr && phase != 2'h0);
   assign dq_oe_o      = active && is_wr;
   assign cyc.done     = active && last_phase && !hold_i;
endmodule

// *** hdl/fbp_host.sv ***
// Host controller for a byte-wide flash: command sequences, block
// protection, unprotection, their verifies and signature reads.
// Assumes high-voltage pins are driven by level shifters from *_hv_o.
`timescale 1ns/1ns
`include "fbp_params.svh"
module fbp_host
   import fbp_pkg::*;
#(
   parameter int UNPROT_CYC = `FBP_UNPROT_CYC,
   parameter int PROT_CYC   = `FBP_PROT_CYC
)
(
   input  wire logic        ref_clk_i,
   input  wire logic        reset_i,
   input  wire logic        op_valid_i,
   input  wire fbp_op_type  op_i,
   input  wire fbp_seq_type seq_i,
   input  wire logic [18:0] op_addr_i,
   input  wire logic [7:0]  op_data_i,
   input  wire logic        temp_unprotect_i,
   output logic             op_ready_o,
   output logic             op_done_o,
   output logic [7:0]       op_rdata_o,
   output logic             block_ok_o,
   input  wire logic [7:0]  dq_i,
   output logic [7:0]       dq_o,
   output logic             dq_oe_o,
   output logic [18:0]      addr_o,
   output logic             chip_en_n_o,
   output logic             write_en_n_o,
   output logic             out_en_n_o,
   output logic             chip_en_hv_o,
   output logic             out_en_hv_o,
   output logic             a9_hv_o,
   output logic             reset_unprotect_pin_hv_o
);
   typedef enum logic [2:0] {ST_IDLE, ST_SEQ, ST_HV_CYC, ST_WAIT, ST_HV_END, ST_DONE} fbp_state_type;

   fbp_cyc_if cyc ();

   fbp_state_type state;
   fbp_op_type    op;
   fbp_seq_type   seq;
   logic [18:0]   addr;
   logic [7:0]    data;
   logic [2:0]    step;
   logic [16:0]   wait_cnt;
   logic          hold;
   logic [18:0]   next_addr;
   logic [7:0]    next_data;
   logic          next_last;

   // Number of written cycles in each instruction
   function automatic logic [2:0] seq_len(input fbp_seq_type s);
      case (s)
         FBP_SEQ_SINGLE:      seq_len = 3'd1;
         FBP_SEQ_PROGRAM:     seq_len = 3'd4;
         FBP_SEQ_BLOCK_ERASE: seq_len = 3'd6;
         FBP_SEQ_CHIP_ERASE:  seq_len = 3'd6;
         default:             seq_len = 3'd3;
      endcase
   endfunction

   // Keep only the block lines of an address, all lower lines low
   function automatic logic [18:0] blk_only(input logic [18:0] a);
      blk_only = {a[18:`FBP_BLK_LSB], 13'h0000};
   endfunction

   // Unlock pairs open the sequence and the erase confirm
   wire unlock_a = (step == 3'd0) || (seq != FBP_SEQ_PROGRAM && step == 3'd3);
   wire unlock_b = (step == 3'd1) || (seq != FBP_SEQ_PROGRAM && step == 3'd4);
   wire is_erase = (seq == FBP_SEQ_BLOCK_ERASE) || (seq == FBP_SEQ_CHIP_ERASE);
   wire [7:0] cmd3 = (seq == FBP_SEQ_SIGNATURE)  ? `FBP_CMD_SIGNATURE :
                     (seq == FBP_SEQ_PROGRAM)    ? `FBP_CMD_PROGRAM :
                     is_erase                    ? `FBP_CMD_ERASE_SETUP :
                                                   `FBP_CMD_READ_RESET;
   wire [7:0] cmd6 = (seq == FBP_SEQ_CHIP_ERASE) ? `FBP_CMD_CHIP_ERASE : `FBP_CMD_BLOCK_ERASE;

   // Address and data of the current written cycle
   always_comb begin
      next_addr = `FBP_UNLOCK_ADDR1;
      next_data = `FBP_UNLOCK_DATA1;
      if (seq == FBP_SEQ_SINGLE) begin
         next_addr = addr;
         next_data = data;
      end else if (unlock_b) begin
         next_addr = `FBP_UNLOCK_ADDR2;
         next_data = `FBP_UNLOCK_DATA2;
      end else if (step == 3'd2) begin
         next_data = cmd3;
      end else if (step == 3'd3 && !unlock_a) begin
         next_addr = addr;                        // Program address and data
         next_data = data;
      end else if (!unlock_a) begin
         next_addr = (seq == FBP_SEQ_CHIP_ERASE) ? `FBP_UNLOCK_ADDR1 : addr;
         next_data = cmd6;
      end
   end
   assign next_last = (step == seq_len(seq) - 3'd1);

   // High-voltage cycle address: block on top lines, plus A1 for both verifies and A6 for the unprotect verify; unprotect uses only A12, A15, signature only A0
   wire [18:0] hv_addr =
      (op == FBP_OP_UNPROTECT)   ? ((19'h1 << `FBP_A12_BIT) | (19'h1 << `FBP_A15_BIT)) :
      (op == FBP_OP_VERIFY_PROT) ? (blk_only(addr) | (19'h1 << `FBP_A1_BIT)) :
      (op == FBP_OP_VERIFY_UNPROT) ?
         (blk_only(addr) | (19'h1 << `FBP_A1_BIT) | (19'h1 << `FBP_A6_BIT)) :
      (op == FBP_OP_SIGNATURE)   ? {18'h00000, addr[`FBP_A0_BIT]} :
                                   blk_only(addr);
   // Timed pulses: software protects every block before one unprotect
   wire hv_wr = (op == FBP_OP_PROTECT) || (op == FBP_OP_UNPROTECT);
   wire hv_live = (state == ST_HV_CYC) || (state == ST_WAIT) || (state == ST_HV_END);
   wire hv_op = (op != FBP_OP_READ) && (op != FBP_OP_WRITE_SEQ);
   wire in_seq = (state == ST_SEQ);

   assign cyc.req   = in_seq || (state == ST_HV_CYC) || (state == ST_IDLE && 1'b0);
   assign cyc.wr    = in_seq ? (op == FBP_OP_WRITE_SEQ) : hv_wr;
   assign cyc.addr  = in_seq ? ((op == FBP_OP_WRITE_SEQ) ? next_addr : addr) : hv_addr;
   assign cyc.wdata = in_seq ? next_data : 8'h00;

   // Freeze the driver from the strobe fall so write enable stays low while timed
   assign hold = (state == ST_WAIT) || (state == ST_HV_CYC && hv_wr && !write_en_n_o);

   // Sequencer
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state <= ST_IDLE;
         op <= FBP_OP_READ;
         seq <= FBP_SEQ_SINGLE;
         addr <= 19'h00000;
         data <= 8'h00;
         step <= 3'd0;
         wait_cnt <= 17'h00000;
         op_rdata_o <= 8'h00;
         block_ok_o <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: if (op_valid_i) begin
               op <= op_i;
               seq <= seq_i;
               addr <= op_addr_i;
               data <= op_data_i;
               step <= 3'd0;
               state <= (op_i == FBP_OP_READ || op_i == FBP_OP_WRITE_SEQ) ? ST_SEQ : ST_HV_CYC;
            end
            ST_SEQ: if (cyc.done) begin
               step <= step + 3'd1;
               op_rdata_o <= dq_i;
               if (op == FBP_OP_READ || next_last) state <= ST_DONE;
            end
            ST_HV_CYC: if (write_en_n_o == 1'b0 && hv_wr) begin
               // Pulse started on the strobe fall; time it from here
               wait_cnt <= (op == FBP_OP_UNPROTECT) ? 17'(UNPROT_CYC) : 17'(PROT_CYC);
               state <= ST_WAIT;
            end else if (cyc.done) begin
               op_rdata_o <= dq_i;
               // Per-block status check of the addressed block
               block_ok_o <= (op == FBP_OP_VERIFY_PROT)   ? (dq_i == `FBP_STAT_PROTECTED) :
                             (op == FBP_OP_VERIFY_UNPROT) ? (dq_i == `FBP_STAT_UNPROT) : 1'b1;
               state <= ST_DONE;
            end
            ST_WAIT: if (wait_cnt <= 17'h00001) begin
               state <= ST_HV_END;
               wait_cnt <= 17'h00000;
            end else begin
               wait_cnt <= wait_cnt - 17'h00001;
            end
            // Strobe released; the pin cycle closes with its done
            ST_HV_END: if (cyc.done) state <= ST_DONE;
            ST_DONE: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // High-voltage pins for the special modes; temporary unprotect is a level
   assign a9_hv_o      = hv_live && hv_op;
   assign out_en_hv_o  = hv_live && hv_wr;
   assign chip_en_hv_o = hv_live && (op == FBP_OP_UNPROTECT);
   assign reset_unprotect_pin_hv_o = temp_unprotect_i;
   assign op_ready_o   = (state == ST_IDLE);
   assign op_done_o    = (state == ST_DONE);

   fbp_bus_cycle u_bus (
      .ref_clk_i    (ref_clk_i),
      .reset_i      (reset_i),
      .cyc          (cyc),
      .hold_i       (hold),
      .dq_i         (dq_i),
      .addr_o       (addr_o),
      .dq_o         (dq_o),
      .dq_oe_o      (dq_oe_o),
      .chip_en_n_o  (chip_en_n_o),
      .write_en_n_o (write_en_n_o),
      .out_en_n_o   (out_en_n_o)
   );

   // Write strobe stays low for the whole timed pulse
   a_pulse_held: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (state == ST_WAIT) |-> !write_en_n_o && a9_hv_o && out_en_hv_o)
      else $error("protect pulse not held");
   // Unprotect pulse carries A12, A15 high and chip enable at high voltage
   a_unprot_arm: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (state == ST_WAIT && op == FBP_OP_UNPROTECT) |->
         addr_o[`FBP_A12_BIT] && addr_o[`FBP_A15_BIT] && chip_en_hv_o)
      else $error("unprotect not armed");
   // Unprotect verify drives A1, A6 high and A0 low
   a_verify_addr: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (!out_en_n_o && op == FBP_OP_VERIFY_UNPROT && state == ST_HV_CYC) |->
         addr_o[`FBP_A1_BIT] && addr_o[`FBP_A6_BIT] && !addr_o[`FBP_A0_BIT] && a9_hv_o)
      else $error("bad unprotect verify address");
   // Temporary unprotect pin follows the request with no memory
   a_temp_level: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      reset_unprotect_pin_hv_o == temp_unprotect_i)
      else $error("temporary unprotect latched");
   // Read and write strobes never overlap
   a_strobe_excl: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !(!write_en_n_o && !out_en_n_o))
      else $error("strobes overlap");
   // First written cycle of a sequence is the first unlock code
   a_unlock_first: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (in_seq && op == FBP_OP_WRITE_SEQ && seq != FBP_SEQ_SINGLE && step == 3'd0 && dq_oe_o)
         |-> dq_o == `FBP_UNLOCK_DATA1)
      else $error("missing unlock");
   // Fifth cycle of an erase is the second unlock code
   a_erase_unlock: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (in_seq && op == FBP_OP_WRITE_SEQ && is_erase && step == 3'd4 && dq_oe_o)
         |-> dq_o == `FBP_UNLOCK_DATA2)
      else $error("erase confirm not unlocked");
   // Done pulse lasts one cycle and the host is ready right after
   a_done_pulse: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      op_done_o |=> !op_done_o && op_ready_o)
      else $error("done not one cycle");
endmodule

// *** tb/fbp_flash_model.sv ***
// Behavioural byte-wide flash device facing the host controller.
// Assumes pins from fbp_host; high-voltage levels arrive as flags.
`timescale 1ns/1ns
`include "fbp_params.svh"
module fbp_flash_model #(
   parameter int   PROT_NS   = 500,
   parameter int   UNPROT_NS = 2000,
   parameter [7:0] MFR_CODE  = 8'h3c,  // Arbitrary maker code
   parameter [7:0] DEV_CODE  = 8'h7d   // Arbitrary device code
)(
   input  wire logic [18:0] addr_i,
   input  wire logic [7:0]  dq_i,
   input  wire logic        chip_en_n_i,
   input  wire logic        write_en_n_i,
   input  wire logic        out_en_n_i,
   input  wire logic        chip_en_hv_i,
   input  wire logic        out_en_hv_i,
   input  wire logic        a9_hv_i,
   input  wire logic        reset_unprotect_pin_hv_i,
   output logic [7:0]       dq_o
);
   logic [7:0]  mem [int];
   logic [63:0] prot = '0;
   logic        sig = 1'b0;
   int          st = 0;
   logic        wact = 1'b0;
   logic        hv_act = 1'b0;
   logic        hv_ce;
   logic [18:0] wa;
   logic [18:0] hv_wa;
   time         t_fall;

   function automatic logic [7:0] read_byte(input logic [18:0] a);
      if (a9_hv_i || sig) begin
         if (!a[1]) return a[0] ? DEV_CODE : MFR_CODE;  // Codes by A0
         if (!a[0]) return prot[a[18:13]] ? 8'h01 : 8'h00;  // Status
         return 8'hff;
      end
      return mem.exists(int'(a)) ? mem[int'(a)] : 8'hff;
   endfunction

   // Erase the chosen block or all, sparing protected ones
   task automatic erase(input logic [5:0] b, input logic all);
      int k[$];
      foreach (mem[i])
         if ((all || i[18:13] == b) && (!prot[i[18:13]] || reset_unprotect_pin_hv_i))
            k.push_back(i);
      foreach (k[j]) mem.delete(k[j]);
   endtask

   // Command interface sequencer
   task automatic command(input logic [18:0] a, input logic [7:0] d);
      logic ok;
      logic u1;
      logic u2;
      // Level-held unprotect
      ok = !prot[a[18:13]] || reset_unprotect_pin_hv_i;
      u1 = a == `FBP_UNLOCK_ADDR1 && d == `FBP_UNLOCK_DATA1;
      u2 = a == `FBP_UNLOCK_ADDR2 && d == `FBP_UNLOCK_DATA2;
      if (st == 3) begin
         if (ok) mem[int'(a)] = d;  // Protected blocks ignored
         st = 0;
      end else if (d == `FBP_CMD_READ_RESET) begin
         st = 0;
         sig = 1'b0;
      end else if (st == 0 || st == 4) st = u1 ? st + 1 : 0;
      else if (st == 1 || st == 5) st = u2 ? st + 1 : 0;
      else if (st == 2 && a == `FBP_UNLOCK_ADDR1 && d == `FBP_CMD_SIGNATURE) begin
         sig = 1'b1;
         st = 0;
      end else if (st == 2 && a == `FBP_UNLOCK_ADDR1 && d == `FBP_CMD_PROGRAM) st = 3;
      else if (st == 2 && a == `FBP_UNLOCK_ADDR1 && d == `FBP_CMD_ERASE_SETUP) st = 4;
      else if (st == 6 && d == `FBP_CMD_BLOCK_ERASE) begin
         erase(a[18:13], 1'b0);
         st = 0;
      end else if (st == 6 && a == `FBP_UNLOCK_ADDR1 && d == `FBP_CMD_CHIP_ERASE) begin
         erase(6'h00, 1'b1);
         st = 0;
      end else begin
         st = 0;  // Broken sequence back to read array
         sig = 1'b0;
      end
   endtask

   // Drive data while read; otherwise show the inverse so a stale bus never matches
   always @(addr_i, chip_en_n_i, out_en_n_i, write_en_n_i, out_en_hv_i, a9_hv_i, sig, prot, st)
      dq_o = (!chip_en_n_i && !out_en_n_i && write_en_n_i && !out_en_hv_i) ?
             read_byte(addr_i) : ~read_byte(addr_i);
   // Address on the later falling strobe
   always @(negedge write_en_n_i or negedge chip_en_n_i)
      if (!write_en_n_i && !chip_en_n_i && out_en_n_i && !out_en_hv_i && !a9_hv_i) begin
         wa = addr_i;
         wact = 1'b1;
      end
   // Data on the earlier rising strobe
   always @(posedge write_en_n_i or posedge chip_en_n_i)
      if (wact) begin
         wact = 1'b0;
         command(wa, dq_i);
      end
   // High-voltage operations start on the write-enable fall
   always @(negedge write_en_n_i)
      if (a9_hv_i && out_en_hv_i) begin
         t_fall = $time;
         hv_wa = addr_i;
         hv_ce = chip_en_hv_i;
         hv_act = 1'b1;
      end
   // Only a strobe held for the full delay completes
   always @(posedge write_en_n_i)
      if (hv_act) begin
         hv_act = 1'b0;
         if (!hv_ce && $time - t_fall >= PROT_NS) prot[hv_wa[18:13]] = 1'b1;
         if (hv_ce && hv_wa[12] && hv_wa[15] && $time - t_fall >= UNPROT_NS) prot = '0;
      end
endmodule

// *** tb/fbp_host_tb.sv ***
// Self-checking bench for fbp_host against a behavioural flash model.
// Assumes a 10 MHz clock and shortened protect/unprotect counts.
`timescale 1ns/1ns
`include "fbp_params.svh"
module fbp_host_tb
   import fbp_pkg::*;
();
   localparam [7:0] MFR = 8'h3c;  // Arbitrary maker code
   localparam [7:0] DEV = 8'h7d;  // Arbitrary device code
   logic        ref_clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        op_valid_i = 1'b0;
   logic        temp_unprotect_i = 1'b0;
   fbp_op_type  op_i = FBP_OP_READ;
   fbp_seq_type seq_i = FBP_SEQ_SINGLE;
   logic [18:0] op_addr_i = '0;
   logic [7:0]  op_data_i = '0;
   logic        op_ready_o, op_done_o, block_ok_o, dq_oe_o, chip_en_n_o, write_en_n_o;
   logic        out_en_n_o, chip_en_hv_o, out_en_hv_o, a9_hv_o, unprot_pin_hv;
   logic [7:0]  op_rdata_o, dq_o, dev_dq, dq_i, r;
   logic [18:0] addr_o;
   int          fails = 0;
   int          n_compared = 0;

   // Data wire: host value while it drives, device value otherwise
   assign dq_i = dq_oe_o ? dq_o : dev_dq;
   always #50 ref_clk_i = ~ref_clk_i;

   fbp_host #(.UNPROT_CYC(20), .PROT_CYC(5)) i_dut (
      .ref_clk_i, .reset_i, .op_valid_i, .op_i, .seq_i, .op_addr_i, .op_data_i,
      .temp_unprotect_i, .op_ready_o, .op_done_o, .op_rdata_o, .block_ok_o, .dq_i, .dq_o,
      .dq_oe_o, .addr_o, .chip_en_n_o, .write_en_n_o, .out_en_n_o, .chip_en_hv_o,
      .out_en_hv_o, .a9_hv_o, .reset_unprotect_pin_hv_o(unprot_pin_hv));
   fbp_flash_model #(.PROT_NS(500), .UNPROT_NS(2000), .MFR_CODE(MFR), .DEV_CODE(DEV)) i_dev (
      .addr_i(addr_o), .dq_i(dq_o), .chip_en_n_i(chip_en_n_o), .write_en_n_i(write_en_n_o),
      .out_en_n_i(out_en_n_o), .chip_en_hv_i(chip_en_hv_o), .out_en_hv_i(out_en_hv_o),
      .a9_hv_i(a9_hv_o), .reset_unprotect_pin_hv_i(unprot_pin_hv), .dq_o(dev_dq));

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   // One host request: wait ready, hold valid for one taking edge, wait done
   task automatic do_op(input fbp_op_type o, input fbp_seq_type s, input logic [18:0] a,
                        input logic [7:0] d);
      int n;
      n = 0;
      @(negedge ref_clk_i);
      while (op_ready_o !== 1'b1 && n < 400) begin
         @(negedge ref_clk_i);
         n++;
      end
      @(posedge ref_clk_i);
      op_i <= o;
      seq_i <= s;
      op_addr_i <= a;
      op_data_i <= d;
      op_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      op_valid_i <= 1'b0;
      n = 0;
      do begin
         @(negedge ref_clk_i);
         n++;
      end while (op_done_o !== 1'b1 && n < 400);
      if (n >= 400) begin
         fails++;
         $display("wrong value at %0t: operation never finished", $time);
      end
      @(negedge ref_clk_i);
      r = op_rdata_o;
   endtask

   task automatic rd_chk(input logic [18:0] a, input logic [7:0] e, input string m);
      do_op(FBP_OP_READ, FBP_SEQ_SINGLE, a, 8'h00);
      chk(r, e, m);
   endtask

   task automatic prog(input logic [18:0] a, input logic [7:0] d);
      do_op(FBP_OP_WRITE_SEQ, FBP_SEQ_PROGRAM, a, d);
   endtask

   task automatic t_signature;
      do_op(FBP_OP_SIGNATURE, FBP_SEQ_SINGLE, 19'h00000, 8'h00);
      chk(r, MFR, "maker code by A9");  // Maker code
      do_op(FBP_OP_SIGNATURE, FBP_SEQ_SINGLE, 19'h00001, 8'h00);
      chk(r, DEV, "device code by A9");  // Device code
      do_op(FBP_OP_WRITE_SEQ, FBP_SEQ_SIGNATURE, 19'h00000, 8'h00);
      rd_chk(19'h00001, DEV, "device code by query");  // Query entry
      rd_chk({6'h09, 13'h0002}, 8'h00, "open block status");  // Status read
      do_op(FBP_OP_WRITE_SEQ, FBP_SEQ_READ_RESET, 19'h00000, 8'h00);
   endtask

   task automatic t_program_and_bad;
      prog(19'h12345, 8'h5a);
      rd_chk(19'h12345, 8'h5a, "programmed byte");  // Program cycles
      do_op(FBP_OP_WRITE_SEQ, FBP_SEQ_SINGLE, 19'h05555, 8'haa);
      do_op(FBP_OP_WRITE_SEQ, FBP_SEQ_SINGLE, 19'h01234, 8'h55);
      do_op(FBP_OP_WRITE_SEQ, FBP_SEQ_SINGLE, 19'h05555, 8'ha0);
      do_op(FBP_OP_WRITE_SEQ, FBP_SEQ_SINGLE, 19'h12346, 8'h66);
      rd_chk(19'h12346, 8'hff, "broken sequence wrote");  // Bad unlock
   endtask

   task automatic t_protect_and_temp;
      do_op(FBP_OP_PROTECT, FBP_SEQ_SINGLE, 19'h12000, 8'h00);
      do_op(FBP_OP_VERIFY_PROT, FBP_SEQ_SINGLE, 19'h12000, 8'h00);
      chk(r, 8'h01, "protect verify");  // Protection
      chk({7'h00, block_ok_o}, 8'h01, "protect verify flag");  // Verify result
      prog(19'h12347, 8'h77);
      rd_chk(19'h12347, 8'hff, "protected block written");  // Ignored write
      @(posedge ref_clk_i);
      temp_unprotect_i <= 1'b1;
      @(negedge ref_clk_i);
      chk({7'h00, unprot_pin_hv}, 8'h01, "unprotect pin high");  // Level follow
      prog(19'h12348, 8'h88);
      rd_chk(19'h12348, 8'h88, "temporary unprotect write");  // Held level
      @(posedge ref_clk_i);
      temp_unprotect_i <= 1'b0;
      @(negedge ref_clk_i);
      chk({7'h00, unprot_pin_hv}, 8'h00, "unprotect pin low");  // Level follow
      prog(19'h12349, 8'h99);
      rd_chk(19'h12349, 8'hff, "protection not restored");  // Restored
   endtask

   task automatic t_erase;
      prog(19'h20010, 8'h11);
      do_op(FBP_OP_WRITE_SEQ, FBP_SEQ_BLOCK_ERASE, 19'h20000, 8'h00);
      rd_chk(19'h20010, 8'hff, "block erase");  // Second unlock pair
      prog(19'h30010, 8'h22);
      do_op(FBP_OP_WRITE_SEQ, FBP_SEQ_CHIP_ERASE, 19'h00000, 8'h00);
      rd_chk(19'h30010, 8'hff, "chip erase");  // Chip erase
      rd_chk(19'h12345, 8'h5a, "protected block erased");  // Kept
   endtask

   task automatic t_unprotect;
      for (int b = 0; b < 64; b++) begin
         do_op(FBP_OP_PROTECT, FBP_SEQ_SINGLE, {b[5:0], 13'h0000}, 8'h00);  // All first
      end
      do_op(FBP_OP_UNPROTECT, FBP_SEQ_SINGLE, 19'h09000, 8'h00);
      for (int b = 0; b < 64; b++) begin
         do_op(FBP_OP_VERIFY_UNPROT, FBP_SEQ_SINGLE, {b[5:0], 13'h0000}, 8'h00);
         chk(r, 8'h00, "unprotect verify");  // Per block
         chk({7'h00, block_ok_o}, 8'h01, "unprotect verify flag");  // Per block
      end
   endtask

   // Main sequence
   initial begin
      repeat (10) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      @(negedge ref_clk_i);
      chk({chip_en_n_o, write_en_n_o, out_en_n_o, op_ready_o, chip_en_hv_o, out_en_hv_o,
           a9_hv_o, dq_oe_o}, 8'hf0, "idle pins after reset");
      t_signature();
      t_program_and_bad();
      t_protect_and_temp();
      t_erase();
      t_unprotect();
      end_sim();
   end

   // Watchdog for a hung handshake
   initial begin
      #(30000 * 100);
      fails++;
      end_sim();
   end
endmodule
